// ===== src/lqv_pkg.sv
// Package for the lock qualifier and blanking-interval detect flag block.
// Assumes one 40 MHz clock domain and an AHB-Lite register slave.
package lqv_pkg;

    // ------------------------------------------------------------
    // Register indexes, byte address = 4x
    // ------------------------------------------------------------
    localparam logic [7:0] LQV_OFF_LOCK_COUNT = 8'h51; // Index, byte = 4x
    localparam logic [7:0] LQV_OFF_FREE_RUN   = 8'h8f; // Index, byte = 4x
    localparam logic [7:0] LQV_OFF_VBI_FLAGS  = 8'h90; // Index, byte = 4x
    localparam logic [7:0] LQV_OFF_IRQ_STATUS = 8'ha0; // Index, byte = 4x
    localparam logic [7:0] LQV_OFF_IRQ_MASK   = 8'ha1; // Index, byte = 4x
    localparam logic [7:0] LQV_OFF_LOCK_STAT  = 8'ha2; // Index, byte = 4x

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LQV_CIL_LSB   = 0; // Count into lock [2:0]
    localparam int LQV_COL_LSB   = 3; // Count out of lock [5:3]
    localparam int LQV_RLS_BIT   = 6; // Raw lock select
    localparam int LQV_FSC_BIT   = 7; // Subcarrier lock enable
    localparam int LQV_PAD_LSB   = 4; // Clock pad select [6:4]

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LQV_RST_LOCK_COUNT = 8'h00;
    localparam logic [7:0] LQV_RST_FREE_RUN   = 8'h00;
    localparam logic [4:0] LQV_RST_IRQ_MASK   = 5'h00;

    // Pad select codes
    localparam logic [2:0] LQV_PAD_PRIMARY = 3'h0;
    localparam logic [2:0] LQV_PAD_HALF    = 3'h5;

    // ------------------------------------------------------------
    // Line counts per 3-bit code
    // ------------------------------------------------------------
    localparam int LQV_CNT_W = 17;
    localparam logic [16:0] LQV_LINES_0 = 17'h00001; // 1 line
    localparam logic [16:0] LQV_LINES_1 = 17'h00002; // 2 lines
    localparam logic [16:0] LQV_LINES_2 = 17'h00005; // 5 lines
    localparam logic [16:0] LQV_LINES_3 = 17'h0000a; // 10 lines
    localparam logic [16:0] LQV_LINES_4 = 17'h00064; // 100 lines
    localparam logic [16:0] LQV_LINES_5 = 17'h001f4; // 500 lines
    localparam logic [16:0] LQV_LINES_6 = 17'h003e8; // 1000 lines
    localparam logic [16:0] LQV_LINES_7 = 17'h186a0; // 100000 lines

    // Raw video-side status, one bundle
    typedef struct packed {
        logic line_strobe;  // One pulse per video line
        logic field_strobe; // One pulse per field
        logic h_lock;       // Horizontal lock
        logic fsc_lock;     // Subcarrier lock
        logic wss_seen;     // Wide screen data seen
        logic ccap_seen;    // Caption sequence seen
        logic edtv_seen;    // EDTV sequence seen
        logic cgms_seen;    // CGMS sequence decoded
    } lqv_raw_t;

endpackage : lqv_pkg

// ===== src/lqv_line_qual.sv
// Line-run qualifier: turns a raw lock level into a qualified status.
// Assumes inputs are already synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module lqv_line_qual
    import lqv_pkg::*;
(
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 line_tick,
    input  wire logic                 raw_lock,
    input  wire logic [LQV_CNT_W-1:0] lines_in,
    input  wire logic [LQV_CNT_W-1:0] lines_out,
    output logic                      locked
);

    logic [LQV_CNT_W-1:0] run_q;    // Unbroken run length
    logic [LQV_CNT_W-1:0] run_d;
    logic                 locked_q; // Qualified status
    logic                 locked_d;

    // ------------------------------------------------------------
    // Run counter and status
    // ------------------------------------------------------------
    // Counts lines that disagree with the present status
    always_comb
    begin
        run_d    = run_q;
        locked_d = locked_q;
        if (raw_lock == locked_q)
        begin
            // Agreement breaks the run, count restarts
            run_d = '0; // [RULE_14]
        end
        else if (line_tick)
        begin
            if (!locked_q && (run_q + 1'b1) >= lines_in)
            begin
                locked_d = 1'b1; // [RULE_01]
                run_d    = '0;
            end
            else if (locked_q && (run_q + 1'b1) >= lines_out)
            begin
                locked_d = 1'b0; // [RULE_02] [RULE_03]
                run_d    = '0;
            end
            else
            begin
                run_d = run_q + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_q    <= '0;
            locked_q <= 1'b0;
        end
        else
        begin
            run_q    <= run_d;
            locked_q <= locked_d;
        end
    end

    assign locked = locked_q;

endmodule : lqv_line_qual
`default_nettype wire

// ===== src/lqv_top.sv
// Lock qualifier, clock pad select and blanking-interval detect flags.
// Assumes raw video status pins are asynchronous; AHB-Lite single slave.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] Lock shown after programmed in-lock line run
// [RULE_02] Lost lock after programmed out-of-lock run
// [RULE_03] Upper out codes: 10 to 100000 lines
// [RULE_04] Select field-based or line-to-line lock evaluation
// [RULE_05] Optionally require subcarrier lock too
// [RULE_06] Software clears subcarrier enable for component input
// [RULE_07] Pad code 000 drives primary line clock
// [RULE_08] Pad code 101 drives half-rate clock
// [RULE_09] Software sets format 0010 for half-rate
// [RULE_10] Software writes reserved free-run bits zero
// [RULE_11] Flags bit0 wide-screen, bit1 caption detected
// [RULE_12] Flag bit2 shows EDTV sequence detected
// [RULE_13] Flag bit3 shows CGMS sequence decoded
// [RULE_14] Broken run restarts the line counter
module lqv_top
    import lqv_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire lqv_raw_t    raw_in,
    input  wire logic        primary_line_clock,
    input  wire logic        half_rate_line_clock,
    output logic             line_clock_out,
    output logic             lock_status,
    output logic             irq
);
    import lqv_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    lqv_raw_t   raw_s1_q;  // First stage, read only by second
    lqv_raw_t   raw_s2_q;  // Usable synchronised copy
    lqv_raw_t   raw_s3_q;  // Delayed copy for edge detection
    logic [1:0] clk_s1_q;  // Clock sampling, first stage
    logic [1:0] clk_s2_q;  // Clock sampling, second stage

    // Two flops per pin before any logic reads them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            raw_s1_q <= '0;
            raw_s2_q <= '0;
            raw_s3_q <= '0;
            clk_s1_q <= '0;
            clk_s2_q <= '0;
        end
        else
        begin
            raw_s1_q <= raw_in;
            raw_s2_q <= raw_s1_q;
            raw_s3_q <= raw_s2_q;
            clk_s1_q <= {half_rate_line_clock, primary_line_clock};
            clk_s2_q <= clk_s1_q;
        end
    end

    logic line_tick;  // One cycle per video line
    logic field_tick; // One cycle per field
    assign line_tick  = raw_s2_q.line_strobe & ~raw_s3_q.line_strobe;
    assign field_tick = raw_s2_q.field_strobe & ~raw_s3_q.field_strobe;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic       ph_wr_q;   // Write data phase pending
    logic       ph_wr_d;
    logic       ph_rd_q;   // Read data phase pending
    logic       ph_rd_d;
    logic [7:0] ph_idx_q;  // Register index of pending phase
    logic [7:0] ph_idx_d;
    logic       addr_ok;   // Taken address phase

    // Size is not decoded: only whole-word transfers occur
    assign addr_ok = hsel & hready & htrans[1];

    // Capture address phase, no wait states
    always_comb
    begin
        ph_wr_d  = addr_ok & hwrite;
        ph_rd_d  = addr_ok & ~hwrite;
        ph_idx_d = addr_ok ? haddr[9:2] : ph_idx_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr_q  <= 1'b0;
            ph_rd_q  <= 1'b0;
            ph_idx_q <= '0;
        end
        else
        begin
            ph_wr_q  <= ph_wr_d;
            ph_rd_q  <= ph_rd_d;
            ph_idx_q <= ph_idx_d;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [7:0] lock_cnt_q;  // Lock count control
    logic [7:0] lock_cnt_d;
    logic [7:0] free_run_q;  // Free run line length one
    logic [7:0] free_run_d;
    logic [4:0] irq_mask_q;  // Interrupt enables
    logic [4:0] irq_mask_d;

    // Writes land in the data phase
    always_comb
    begin
        lock_cnt_d = lock_cnt_q;
        free_run_d = free_run_q;
        irq_mask_d = irq_mask_q;
        if (ph_wr_q)
        begin
            unique case (ph_idx_q)
                LQV_OFF_LOCK_COUNT: lock_cnt_d = hwdata[7:0];
                // Reserved bits are expected written as zero
                LQV_OFF_FREE_RUN:   free_run_d = hwdata[7:0]; // [RULE_10]
                LQV_OFF_IRQ_MASK:   irq_mask_d = hwdata[4:0];
                default:            ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_cnt_q <= LQV_RST_LOCK_COUNT;
            free_run_q <= LQV_RST_FREE_RUN;
            irq_mask_q <= LQV_RST_IRQ_MASK;
        end
        else
        begin
            lock_cnt_q <= lock_cnt_d;
            free_run_q <= free_run_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ------------------------------------------------------------
    // Line count decode
    // ------------------------------------------------------------
    // Same table for both directions
    function automatic logic [LQV_CNT_W-1:0] lines_of(input logic [2:0] c);
        logic [LQV_CNT_W-1:0] n;
        unique case (c)
            3'h0: n = LQV_LINES_0;
            3'h1: n = LQV_LINES_1;
            3'h2: n = LQV_LINES_2;
            3'h3: n = LQV_LINES_3;
            3'h4: n = LQV_LINES_4;
            3'h5: n = LQV_LINES_5;
            3'h6: n = LQV_LINES_6;
            3'h7: n = LQV_LINES_7;
        endcase
        return n;
    endfunction : lines_of

    logic [2:0] count_into_lock;        // Entry code
    logic [2:0] count_out_of_lock;      // Exit code
    logic       raw_lock_select;        // 1: line-to-line
    logic       subcarrier_lock_enable; // 1: need subcarrier too
    assign count_into_lock        = lock_cnt_q[LQV_CIL_LSB +: 3];
    assign count_out_of_lock      = lock_cnt_q[LQV_COL_LSB +: 3];
    assign raw_lock_select        = lock_cnt_q[LQV_RLS_BIT];
    assign subcarrier_lock_enable = lock_cnt_q[LQV_FSC_BIT];

    // ------------------------------------------------------------
    // Raw lock condition
    // ------------------------------------------------------------
    logic cond_now;     // Instant lock condition
    logic field_ok_q;   // Condition held for the whole field
    logic field_ok_d;
    logic field_lock_q; // Field verdict
    logic field_lock_d;
    logic raw_lock;     // Chosen raw lock

    // Subcarrier term only when enabled
    assign cond_now = raw_s2_q.h_lock &
                      (raw_s2_q.fsc_lock | ~subcarrier_lock_enable); // [RULE_05]

    // Field mode latches a verdict at each field boundary
    always_comb
    begin
        field_ok_d   = field_ok_q & cond_now;
        field_lock_d = field_lock_q;
        if (field_tick)
        begin
            field_lock_d = field_ok_q & cond_now; // [RULE_04]
            field_ok_d   = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            field_ok_q   <= 1'b1;
            field_lock_q <= 1'b0;
        end
        else
        begin
            field_ok_q   <= field_ok_d;
            field_lock_q <= field_lock_d;
        end
    end

    // Trade-off: field mode reacts only once per field
    assign raw_lock = raw_lock_select ? cond_now : field_lock_q; // [RULE_04]

    logic locked; // Qualified lock

    lqv_line_qual u_qual (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .line_tick (line_tick),
        .raw_lock  (raw_lock),
        .lines_in  (lines_of(count_into_lock)),
        .lines_out (lines_of(count_out_of_lock)),
        .locked    (locked)
    );

    // ------------------------------------------------------------
    // Status, interrupts and outputs
    // ------------------------------------------------------------
    logic [3:0] vbi_flags;   // Detect flags, live
    logic [4:0] irq_ev;      // Event pulses
    logic [4:0] irq_stat_q;  // Sticky events
    logic [4:0] irq_stat_d;
    logic       lock_q;      // Registered lock status
    logic       irq_q;       // Registered interrupt
    logic       clk_out_q;   // Registered pad clock
    logic       clk_out_d;
    logic [2:0] output_clock_pad_select;

    assign vbi_flags = {raw_s2_q.cgms_seen,   // [RULE_13]
                        raw_s2_q.edtv_seen,   // [RULE_12]
                        raw_s2_q.ccap_seen,   // [RULE_11]
                        raw_s2_q.wss_seen};   // [RULE_11]
    assign irq_ev = {locked ^ lock_q,
                     raw_s2_q.cgms_seen & ~raw_s3_q.cgms_seen,
                     raw_s2_q.edtv_seen & ~raw_s3_q.edtv_seen,
                     raw_s2_q.ccap_seen & ~raw_s3_q.ccap_seen,
                     raw_s2_q.wss_seen  & ~raw_s3_q.wss_seen};
    assign output_clock_pad_select = free_run_q[LQV_PAD_LSB +: 3];

    // Set wins over write-one-to-clear
    always_comb
    begin
        irq_stat_d = irq_stat_q;
        // Clear on a status data phase
        if (ph_wr_q && ph_idx_q == LQV_OFF_IRQ_STATUS)
        begin
            irq_stat_d = irq_stat_q & ~hwdata[4:0];
        end
        // Applied last, so an event in the clear cycle stays
        irq_stat_d = irq_stat_d | irq_ev;
    end

    // Pad clock: sampled copy, a 40 MHz clock cannot carry 27 MHz
    always_comb
    begin
        if (output_clock_pad_select == LQV_PAD_HALF)
        begin
            clk_out_d = clk_s2_q[1]; // [RULE_08]
        end
        else
        begin
            // Every other code falls back to primary
            clk_out_d = clk_s2_q[0]; // [RULE_07]
        end
    end

    // Registered at the address edge, so the data
    // stands exactly during the data phase
    logic [31:0] rd_d; // Read mux
    always_comb
    begin
        rd_d = '0;
        unique case (ph_idx_d)
            LQV_OFF_LOCK_COUNT: rd_d[7:0] = lock_cnt_q;
            LQV_OFF_FREE_RUN:   rd_d[7:0] = free_run_q;
            LQV_OFF_VBI_FLAGS:  rd_d[3:0] = vbi_flags;
            LQV_OFF_IRQ_STATUS: rd_d[4:0] = irq_stat_q;
            LQV_OFF_IRQ_MASK:   rd_d[4:0] = irq_mask_q;
            LQV_OFF_LOCK_STAT:  rd_d[0]   = locked;
            default:            ;
        endcase
        // Idle cycles read as zero
        if (!ph_rd_d)
        begin
            rd_d = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_q <= '0;
            lock_q     <= 1'b0;
            irq_q      <= 1'b0;
            clk_out_q  <= 1'b0;
            hrdata     <= '0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            lock_q     <= locked;
            irq_q      <= |(irq_stat_d & irq_mask_d);
            clk_out_q  <= clk_out_d;
            hrdata     <= rd_d;
        end
    end

    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign lock_status    = lock_q;
    assign irq            = irq_q;
    assign line_clock_out = clk_out_q;

endmodule : lqv_top
`default_nettype wire

// ===== sim/lqv_top_properties.sv
// Port-level checker for the lock qualifier and detect flag block.
// Assumes one hclk domain; bound onto lqv_top from the bench.
`timescale 1ns/1ps
`default_nettype none
module lqv_checker
(
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic             hready,
    input wire logic [31:0]      hrdata,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire lqv_pkg::lqv_raw_t raw_in,
    input wire logic             primary_line_clock,
    input wire logic             half_rate_line_clock,
    input wire logic             line_clock_out,
    input wire logic             lock_status,
    input wire logic             irq
);
    import lqv_pkg::*;

    // ------------------------------------------------------------
    // Helper decode
    // ------------------------------------------------------------
    localparam logic [31:0] VBI_ADDR = {22'h0, LQV_OFF_VBI_FLAGS, 2'b00};
    logic       rd_go; // Read address phase taken
    logic       wr_go; // Write address phase taken
    logic [3:0] flg;   // Raw detect flags in register order
    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wr_go = hsel && hready && htrans[1] && hwrite;
    assign flg = {raw_in.cgms_seen, raw_in.edtv_seen,
                  raw_in.ccap_seen, raw_in.wss_seen};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ready_ok;
        hreadyout && !hresp;
    endproperty
    a_ready_ok: assert property (p_ready_ok)
        else $error("slave stalled or answered with an error");
    property p_idle_rdata;
        !$past(rd_go) |-> hrdata == 32'h0;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data outside a read data phase");
    property p_upper_zero;
        hrdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unused read data bits set");
    // Five quiet cycles let the synchroniser settle first
    property p_flags_read;
        ($stable(flg) [*5] ##0 (rd_go && haddr == VBI_ADDR))
            |=> hrdata[3:0] == $past(flg);
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("detect flags read wrong");
    property p_lock_quiet;
        (!raw_in.line_strobe) [*8] |-> $stable(lock_status);
    endproperty
    a_lock_quiet: assert property (p_lock_quiet)
        else $error("lock status moved without a line");
    property p_pad_agree;
        ($past(hresetn, 5) && $stable(primary_line_clock) &&
         primary_line_clock == half_rate_line_clock) [*5]
            |-> line_clock_out == primary_line_clock;
    endproperty
    a_pad_agree: assert property (p_pad_agree)
        else $error("clock pin differs from both sources");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_go, 2) || $past(wr_go, 3) || $past(wr_go, 4);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped with no write");
    property p_reset_out;
        $rose(hresetn) |-> !lock_status && !irq && !line_clock_out;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not idle after reset");
endmodule : lqv_checker
`default_nettype wire

// ===== sim/test_lock_qualify_vbi_detect_flags.sv
// Self-checking bench for lqv_top over AHB-Lite register accesses.
// Assumes the checker file is compiled first; bench drives raw status.
`timescale 1ns/1ps
`default_nettype none
module test_lock_qualify_vbi_detect_flags;
    import lqv_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    lqv_raw_t    raw_q = '0;       // Raw video status
    logic        prim = 1'b0;      // Primary line clock level
    logic        half = 1'b0;      // Half-rate clock level
    logic        clk_out;
    logic        lock_status;
    logic        irq;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n_tab[7] = '{1, 2, 5, 10, 100, 500, 1000};

    always #12.5 hclk = ~hclk;

    lqv_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .raw_in(raw_q),
        .primary_line_clock(prim), .half_rate_line_clock(half),
        .line_clock_out(clk_out), .lock_status(lock_status), .irq(irq));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("BAD %0t got %h want %h", $time, seen, exp);
            miscompares++;
        end
    endtask : check

    // One single transfer; holds each phase until hready is seen
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] v;
        xfer(1'b1, idx, d, v);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, idx, 32'h0, v);
        check(v, exp);
    endtask : rd

    // Settle, n line pulses, then settle again
    task automatic lines(input int n);
        repeat (4) @(posedge hclk);
        repeat (n)
        begin
            raw_q.line_strobe <= 1'b1;
            repeat (2) @(posedge hclk);
            raw_q.line_strobe <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask : lines

    task automatic fld;
        raw_q.field_strobe <= 1'b1;
        repeat (2) @(posedge hclk);
        raw_q.field_strobe <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : fld

    // Hang guard; tests need roughly 13500 cycles
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(LQV_OFF_LOCK_COUNT, 32'h0);
        rd(LQV_OFF_FREE_RUN, 32'h0);
        rd(LQV_OFF_IRQ_MASK, 32'h0);
        rd(LQV_OFF_IRQ_STATUS, 32'h0);
        rd(LQV_OFF_LOCK_STAT, 32'h0);
        wr(8'h10, 32'hff);
        rd(8'h10, 32'h0);
        // Each flag alone, also raising its sticky status bit
        for (int i = 0; i < 4; i++)
        begin
            raw_q.wss_seen <= (i == 0);
            raw_q.ccap_seen <= (i == 1);
            raw_q.edtv_seen <= (i == 2);
            raw_q.cgms_seen <= (i == 3);
            repeat (6) @(posedge hclk);
            rd(LQV_OFF_VBI_FLAGS, 1 << i);
        end
        check(32'(irq), 32'h0);
        rd(LQV_OFF_IRQ_STATUS, 32'h0f);
        wr(LQV_OFF_IRQ_MASK, 32'h0f);
        repeat (4) @(posedge hclk);
        check(32'(irq), 32'h1);
        wr(LQV_OFF_VBI_FLAGS, 32'hff);
        rd(LQV_OFF_VBI_FLAGS, 32'h8);
        wr(LQV_OFF_IRQ_STATUS, 32'h0f);
        repeat (4) @(posedge hclk);
        check(32'(irq), 32'h0);
        rd(LQV_OFF_IRQ_STATUS, 32'h0);
        // Pad selection with all source level pairs
        for (int v = 0; v < 4; v++)
        begin
            prim <= v[0];
            half <= v[1];
            wr(LQV_OFF_FREE_RUN, 32'h0);
            repeat (5) @(posedge hclk);
            check(32'(clk_out), 32'(v[0]));
            // Half-rate pad; format 0010 is set in a neighbour block
            wr(LQV_OFF_FREE_RUN, 32'h50);
            repeat (5) @(posedge hclk);
            check(32'(clk_out), 32'(v[1]));
        end
        rd(LQV_OFF_FREE_RUN, 32'h50);
        // Every practical count code, line-to-line mode
        for (int c = 0; c < 7; c++)
        begin
            wr(LQV_OFF_LOCK_COUNT, {24'h0, 2'b01, c[2:0], c[2:0]});
            raw_q.h_lock <= 1'b1;
            lines(n_tab[c] - 1);
            check(32'(lock_status), 32'h0);
            lines(1);
            check(32'(lock_status), 32'h1);
            raw_q.h_lock <= 1'b0;
            lines(n_tab[c] - 1);
            check(32'(lock_status), 32'h1);
            lines(1);
            check(32'(lock_status), 32'h0);
        end
        // Lock changes leave only the lock event bit set
        rd(LQV_OFF_IRQ_STATUS, 32'h10);
        // Broken run of five restarts the count
        wr(LQV_OFF_LOCK_COUNT, 32'h52);
        raw_q.h_lock <= 1'b1;
        lines(3);
        raw_q.h_lock <= 1'b0;
        lines(1);
        raw_q.h_lock <= 1'b1;
        lines(4);
        check(32'(lock_status), 32'h0);
        lines(1);
        check(32'(lock_status), 32'h1);
        // Subcarrier lock also required
        wr(LQV_OFF_LOCK_COUNT, 32'hc0);
        lines(2);
        check(32'(lock_status), 32'h0);
        raw_q.fsc_lock <= 1'b1;
        lines(1);
        check(32'(lock_status), 32'h1);
        raw_q.h_lock <= 1'b0;
        raw_q.fsc_lock <= 1'b0;
        lines(1);
        // Field mode uses the verdict of the last whole field
        wr(LQV_OFF_LOCK_COUNT, 32'h0);
        fld();
        raw_q.h_lock <= 1'b1;
        lines(2);
        check(32'(lock_status), 32'h0);
        fld();
        fld();
        lines(1);
        check(32'(lock_status), 32'h1);
        raw_q.h_lock <= 1'b0;
        lines(2);
        check(32'(lock_status), 32'h1);
        fld();
        lines(1);
        check(32'(lock_status), 32'h0);
        conclude();
    end
endmodule : test_lock_qualify_vbi_detect_flags

bind lqv_top lqv_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .raw_in(raw_in),
    .primary_line_clock(primary_line_clock),
    .half_rate_line_clock(half_rate_line_clock),
    .line_clock_out(line_clock_out), .lock_status(lock_status),
    .irq(irq));
`default_nettype wire
